/* pmbf_pkg.sv */
// Shared constants, codes and carrier types for the burst write closing engine.
package pmbf_pkg;

   // ----------------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------------
   localparam int AD_W = 64;
   localparam int CBE_W = 8;
   localparam int HALF_W = 32;
   localparam int HALF_CBE_W = 4;
   localparam int CNT_W = 8;
   localparam int CODE_W = 4;
   localparam int TERM_W = 2;

   // ----------------------------------------------------------------------
   // Master state codes shown on the status output (plain defaults)
   // ----------------------------------------------------------------------
   localparam logic [CODE_W-1:0] CODE_IDLE = 4'h0;
   localparam logic [CODE_W-1:0] CODE_DATA = 4'h3;
   localparam logic [CODE_W-1:0] CODE_BUS_TERM = 4'h5;

   // ----------------------------------------------------------------------
   // Termination kinds
   // ----------------------------------------------------------------------
   localparam logic [TERM_W-1:0] TERM_NONE = 2'h0;
   localparam logic [TERM_W-1:0] TERM_NORMAL = 2'h1;

   // ----------------------------------------------------------------------
   // Counter constants
   // ----------------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_TWO = 8'h02;

   // ----------------------------------------------------------------------
   // Levels of active-low bus signals
   // ----------------------------------------------------------------------
   localparam logic ASSERTED_N = 1'b0;
   localparam logic DEASSERTED_N = 1'b1;

   // Sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DATA = 2'b01,
      ST_LAST = 2'b10,
      ST_TURN = 2'b11
   } pmbf_state_t;

   // Lines the engine drives toward the PCI bus, each with its enable.
   typedef struct packed {
      logic [AD_W-1:0] ad;
      logic adOe;
      logic [CBE_W-1:0] cbe;
      logic cbeOe;
      logic frameN;
      logic frameOe;
      logic req64N;
      logic req64Oe;
      logic irdyN;
      logic irdyOe;
   } pmbf_pci_out_t;

   // Data offered by the local master.
   typedef struct packed {
      logic [AD_W-1:0] data;
      logic [CBE_W-1:0] byteEn;
      logic readyN;
   } pmbf_local_in_t;

endpackage

/* pmbf_word_counter.sv */
// Down counter of data phases still owed in the current burst.
`timescale 1ns/10ps
module pmbf_word_counter #(
   parameter int CNT_W = pmbf_pkg::CNT_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [CNT_W-1:0] loadValue,
   input wire logic dec,
   output logic [CNT_W-1:0] count
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0] count;
   } pmbf_cnt_state_t;

   pmbf_cnt_state_t state_reg;
   pmbf_cnt_state_t state_next;

   // Load wins over a decrement; the counter never wraps below zero.
   always_comb begin
      state_next = state_reg;
      if (load) begin
         state_next.count = loadValue;
      end else if (dec && (state_reg.count != '0)) begin
         state_next.count = state_reg.count - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Registers the counter.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign count = state_reg.count;

endmodule

/* pmbf_burst_finish.sv */
// Data phase and closing sequencer of a 64-bit PCI burst write as initiator.
`timescale 1ns/10ps
module pmbf_burst_finish #(
   parameter int CNT_W = pmbf_pkg::CNT_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [CNT_W-1:0] burstLength,
   input pmbf_pkg::pmbf_local_in_t localIn,
   input wire logic trdyN,
   input wire logic devselN,
   input wire logic ack64N,
   output pmbf_pkg::pmbf_pci_out_t pciOut,
   output logic lowHalfTransferN,
   output logic highHalfTransferN,
   output logic [CNT_W-1:0] burstWordsRemaining,
   output logic [pmbf_pkg::CODE_W-1:0] masterStateCode,
   output logic [pmbf_pkg::TERM_W-1:0] terminationKind,
   output logic burstDone
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      pmbf_pkg::pmbf_state_t fsm;
      pmbf_pkg::pmbf_pci_out_t pci;
      logic lowXferN;
      logic highXferN;
      logic readyPrevN;
      logic [pmbf_pkg::CODE_W-1:0] code;
      logic [pmbf_pkg::TERM_W-1:0] term;
      logic done;
   } pmbf_main_state_t;

   pmbf_main_state_t state_reg;
   pmbf_main_state_t state_next;

   logic [CNT_W-1:0] phaseCount;
   logic counterLoad;
   logic counterDec;
   logic phaseComplete;
   logic takeLocal;
   logic loadIsLast;
   logic unusedTargetLines;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   // Tells whether the pair about to be loaded is the final one of the burst.
   function automatic logic pair_is_last(
      input logic [CNT_W-1:0] owed,
      input logic completing
   );
      logic result;
      result = 1'b0;
      if (completing) begin
         result = (owed == CNT_W'(pmbf_pkg::CNT_TWO));
      end else begin
         result = (owed == CNT_W'(pmbf_pkg::CNT_ONE));
      end
      return result;
   endfunction

   // Counter of data phases not yet completed on the bus.
   pmbf_word_counter #(
      .CNT_W(CNT_W)
   ) u_counter (
      .clk(clk),
      .rst(rst),
      .load(counterLoad),
      .loadValue(burstLength),
      .dec(counterDec),
      .count(phaseCount)
   );

   // A phase completes only while this engine drives initiator ready low.
   assign phaseComplete = state_reg.pci.irdyOe &&
                          (state_reg.pci.irdyN == pmbf_pkg::ASSERTED_N) &&
                          (trdyN == pmbf_pkg::ASSERTED_N);

   // The decrement is registered in the counter, so it shows one cycle later.
   assign counterDec = phaseComplete;

   // A new burst loads the counter with its length of 64-bit phases.
   assign counterLoad = (state_reg.fsm == pmbf_pkg::ST_IDLE) && start &&
                        (localIn.readyN == pmbf_pkg::ASSERTED_N) &&
                        (burstLength != CNT_W'(pmbf_pkg::CNT_ZERO));

   // Local data is taken in a data state once the bus slot is free.
   assign takeLocal = (state_reg.fsm == pmbf_pkg::ST_DATA) &&
                      (phaseComplete ||
                       (state_reg.pci.irdyN == pmbf_pkg::DEASSERTED_N)) &&
                      (state_reg.readyPrevN == pmbf_pkg::ASSERTED_N);

   assign loadIsLast = pair_is_last(phaseCount, phaseComplete);

   // Target select lines are not needed for a normal end and are only observed.
   assign unusedTargetLines = devselN ^ ack64N;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------

   // Computes the next bus drive, strobes and status for every state.
   always_comb begin
      state_next = state_reg;
      state_next.readyPrevN = localIn.readyN;
      state_next.lowXferN = pmbf_pkg::DEASSERTED_N;
      state_next.highXferN = pmbf_pkg::DEASSERTED_N;
      state_next.done = 1'b0;
      case (state_reg.fsm)
         pmbf_pkg::ST_IDLE: begin
            state_next.pci.irdyOe = 1'b0;
            state_next.pci.irdyN = pmbf_pkg::DEASSERTED_N;
            state_next.code = pmbf_pkg::CODE_IDLE;
            if (counterLoad) begin
               // First pair goes straight onto the bus with all drivers on.
               state_next.pci.ad = localIn.data;
               state_next.pci.cbe = localIn.byteEn;
               state_next.pci.adOe = 1'b1;
               state_next.pci.cbeOe = 1'b1;
               state_next.pci.frameOe = 1'b1;
               state_next.pci.req64Oe = 1'b1;
               state_next.pci.irdyOe = 1'b1;
               state_next.pci.irdyN = pmbf_pkg::ASSERTED_N;
               state_next.lowXferN = pmbf_pkg::ASSERTED_N;
               state_next.highXferN = pmbf_pkg::ASSERTED_N;
               state_next.term = pmbf_pkg::TERM_NONE;
               state_next.code = pmbf_pkg::CODE_DATA;
               if (burstLength == CNT_W'(pmbf_pkg::CNT_ONE)) begin
                  state_next.pci.frameN = pmbf_pkg::DEASSERTED_N;
                  state_next.pci.req64N = pmbf_pkg::DEASSERTED_N;
                  state_next.fsm = pmbf_pkg::ST_LAST;
               end else begin
                  state_next.pci.frameN = pmbf_pkg::ASSERTED_N;
                  state_next.pci.req64N = pmbf_pkg::ASSERTED_N;
                  state_next.fsm = pmbf_pkg::ST_DATA;
               end
            end
         end
         pmbf_pkg::ST_DATA: begin
            state_next.pci.frameN = pmbf_pkg::ASSERTED_N;
            state_next.pci.req64N = pmbf_pkg::ASSERTED_N;
            if (takeLocal) begin
               // Next pair follows the accepted one; each strobe owns a half.
               state_next.pci.ad[pmbf_pkg::HALF_W-1:0] =
                  localIn.data[pmbf_pkg::HALF_W-1:0];
               state_next.pci.ad[pmbf_pkg::AD_W-1:pmbf_pkg::HALF_W] =
                  localIn.data[pmbf_pkg::AD_W-1:pmbf_pkg::HALF_W];
               state_next.pci.cbe[pmbf_pkg::HALF_CBE_W-1:0] =
                  localIn.byteEn[pmbf_pkg::HALF_CBE_W-1:0];
               state_next.pci.cbe[pmbf_pkg::CBE_W-1:pmbf_pkg::HALF_CBE_W] =
                  localIn.byteEn[pmbf_pkg::CBE_W-1:pmbf_pkg::HALF_CBE_W];
               state_next.lowXferN = pmbf_pkg::ASSERTED_N;
               state_next.highXferN = pmbf_pkg::ASSERTED_N;
               // Ready seen last cycle holds initiator ready on.
               state_next.pci.irdyN = pmbf_pkg::ASSERTED_N;
               if (loadIsLast) begin
                  state_next.pci.frameN = pmbf_pkg::DEASSERTED_N;
                  state_next.pci.req64N = pmbf_pkg::DEASSERTED_N;
                  state_next.fsm = pmbf_pkg::ST_LAST;
               end
            end else if (phaseComplete) begin
               // No fresh local data: pause the bus with wait states.
               state_next.pci.irdyN = pmbf_pkg::DEASSERTED_N;
            end
         end
         pmbf_pkg::ST_LAST: begin
            // Final phase: strobes stay high so no further local data is taken.
            state_next.lowXferN = pmbf_pkg::DEASSERTED_N;
            state_next.highXferN = pmbf_pkg::DEASSERTED_N;
            if (phaseComplete) begin
               state_next.pci.adOe = 1'b0;
               state_next.pci.cbeOe = 1'b0;
               state_next.pci.frameOe = 1'b0;
               state_next.pci.req64Oe = 1'b0;
               state_next.pci.irdyN = pmbf_pkg::DEASSERTED_N;
               state_next.code = pmbf_pkg::CODE_BUS_TERM;
               state_next.term = pmbf_pkg::TERM_NORMAL;
               state_next.done = 1'b1;
               state_next.fsm = pmbf_pkg::ST_TURN;
            end
         end
         pmbf_pkg::ST_TURN: begin
            // Target ready is ignored here, as the target is releasing it.
            state_next.pci.irdyOe = 1'b0;
            state_next.pci.irdyN = pmbf_pkg::DEASSERTED_N;
            state_next.code = pmbf_pkg::CODE_IDLE;
            state_next.fsm = pmbf_pkg::ST_IDLE;
         end
         default: begin
            state_next.fsm = pmbf_pkg::ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------

   // Registers the whole state; reset leaves the bus released and idle.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.fsm <= pmbf_pkg::ST_IDLE;
         state_reg.pci.frameN <= pmbf_pkg::DEASSERTED_N;
         state_reg.pci.req64N <= pmbf_pkg::DEASSERTED_N;
         state_reg.pci.irdyN <= pmbf_pkg::DEASSERTED_N;
         state_reg.lowXferN <= pmbf_pkg::DEASSERTED_N;
         state_reg.highXferN <= pmbf_pkg::DEASSERTED_N;
         state_reg.readyPrevN <= pmbf_pkg::DEASSERTED_N;
         state_reg.code <= pmbf_pkg::CODE_IDLE;
         state_reg.term <= pmbf_pkg::TERM_NONE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------

   // Every output is a flip-flop of the state or of the counter.
   assign pciOut = state_reg.pci;
   assign lowHalfTransferN = state_reg.lowXferN;
   assign highHalfTransferN = state_reg.highXferN;
   assign burstWordsRemaining = phaseCount;
   assign masterStateCode = state_reg.code;
   assign terminationKind = state_reg.term;
   assign burstDone = state_reg.done;

endmodule

/* pmbf_burst_finish_checker.sv */
// Assertion checker for the burst write closing engine, bound to its ports.
`timescale 1ns/10ps
module pmbf_burst_finish_checker #(
   parameter int CNT_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input pmbf_pkg::pmbf_local_in_t localIn,
   input wire logic trdyN,
   input pmbf_pkg::pmbf_pci_out_t pciOut,
   input wire logic lowHalfTransferN,
   input wire logic highHalfTransferN,
   input wire logic [CNT_W-1:0] burstWordsRemaining,
   input wire logic [pmbf_pkg::CODE_W-1:0] masterStateCode,
   input wire logic [pmbf_pkg::TERM_W-1:0] terminationKind,
   input wire logic burstDone
);
   // A phase completes when both ready lines are low while the engine drives.
   wire logic phaseDone = pciOut.irdyOe & ~pciOut.irdyN & ~trdyN;
   wire logic lastDone = phaseDone & pciOut.frameN;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_strobe_pair: assert property (lowHalfTransferN == highHalfTransferN)
      else $error("half strobes differ");
   chk_count_step: assert property (phaseDone && burstWordsRemaining != 0 |=>
      burstWordsRemaining == $past(burstWordsRemaining) - 1'h1)
      else $error("counter did not step after completion");
   chk_frame_held: assert property (pciOut.frameOe && burstWordsRemaining > 1 |->
      !pciOut.frameN) else $error("frame dropped early");
   chk_last_phase: assert property (pciOut.irdyOe && !pciOut.irdyN &&
      burstWordsRemaining == 1 |-> pciOut.frameN && pciOut.req64N)
      else $error("frame or req64 held in last phase");
   chk_no_late_strobe: assert property (lastDone |=> lowHalfTransferN ##1
      lowHalfTransferN) else $error("strobe after last phase");
   chk_turn_release: assert property (lastDone |=> !pciOut.adOe && !pciOut.cbeOe &&
      !pciOut.frameOe && !pciOut.req64Oe) else $error("bus not released");
   chk_turn_idle: assert property (lastDone |=> pciOut.irdyN &&
      burstWordsRemaining == 0 && burstDone) else $error("turnaround state wrong");
   chk_term_normal: assert property (lastDone |=>
      masterStateCode == pmbf_pkg::CODE_BUS_TERM &&
      terminationKind == pmbf_pkg::TERM_NORMAL) else $error("termination not reported");
   chk_pair_taken: assert property (phaseDone && !pciOut.frameN &&
      !$past(localIn.readyN) |=> !pciOut.irdyN && !lowHalfTransferN &&
      pciOut.ad == $past(localIn.data) && pciOut.cbe == $past(localIn.byteEn))
      else $error("next pair not driven");
endmodule
bind pmbf_burst_finish pmbf_burst_finish_checker #(.CNT_W(CNT_W)) chk_i (.clk, .rst,
   .localIn, .trdyN, .pciOut, .lowHalfTransferN, .highHalfTransferN,
   .burstWordsRemaining, .masterStateCode, .terminationKind, .burstDone);

/* pmbf_pci_target.sv */
// Behavioural 64-bit PCI target that answers the engine, with optional wait states.
`timescale 1ns/10ps
module pmbf_pci_target (
   input pmbf_pkg::pmbf_pci_out_t pciOut,
   input wire logic stall,
   output logic trdyN,
   output logic devselN,
   output logic ack64N
);
   logic active;
   // Claim the cycle while frame or initiator ready is held; let go in turnaround.
   always_comb begin
      active = (pciOut.frameOe & ~pciOut.frameN) | (pciOut.irdyOe & ~pciOut.irdyN);
      devselN = ~active;
      ack64N = ~active;
      trdyN = ~(active & ~stall);
   end
endmodule

/* pmbf_burst_finish_tb_top.sv */
// Self-checking testbench of the burst write closing engine.
`timescale 1ns/10ps
module pmbf_burst_finish_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic stall = 1'b0;
   logic [7:0] burstLength = 8'h00;
   pmbf_pkg::pmbf_local_in_t localIn = '{64'h0, 8'hFF, 1'b1};
   pmbf_pkg::pmbf_pci_out_t pciOut;
   logic trdyN, devselN, ack64N, lowN, highN, burstDone;
   logic [7:0] burstWordsRemaining;
   logic [3:0] masterStateCode;
   logic [1:0] terminationKind;
   int errors = 0;
   int totalChecks = 0;
   int cycles = 0;

   pmbf_burst_finish pmbf_burst_finish_i (.clk(clk), .rst(rst), .start(start),
      .burstLength(burstLength), .localIn(localIn), .trdyN(trdyN), .devselN(devselN),
      .ack64N(ack64N), .pciOut(pciOut), .lowHalfTransferN(lowN), .highHalfTransferN(highN),
      .burstWordsRemaining(burstWordsRemaining), .masterStateCode(masterStateCode),
      .terminationKind(terminationKind), .burstDone(burstDone));
   pmbf_pci_target pmbf_pci_target_i (.pciOut(pciOut), .stall(stall), .trdyN(trdyN),
      .devselN(devselN), .ack64N(ack64N));

   // The clock toggles every 5 ns, a period of 10 ns.
   always #5 clk = ~clk;

   // A hang is cut short after far more cycles than the tests need.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         errors++;
         testDone();
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic testDone();
      $display("checks %0d mismatches %0d", totalChecks, errors);
      if (errors == 0 && totalChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      totalChecks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Data pair and byte enables that the local side offers as pair k.
   function automatic logic [63:0] patWord(input int k);
      return {32'hA5C30000 | 32'(k), 32'h3C5A0000 | 32'(k)};
   endfunction
   function automatic logic [7:0] patEnable(input int k);
      return 8'(k) ^ 8'h5A;
   endfunction

   // Acts as local master through one burst and checks every phase and the close.
   task automatic runBurst(input int len, input int stallAt, input int pauseAt);
      int k, got, pause;
      logic prevRdy, comp, take, lastTake;
      k = 0;
      got = 0;
      pause = 0;
      prevRdy = 1'b0;
      lastTake = 1'b0;
      start <= 1'b1;
      burstLength <= 8'(len);
      localIn <= '{patWord(0), patEnable(0), 1'b0};
      for (int c = 0; c < 80 && got < len; c++) begin
         @(posedge clk);
         comp = pciOut.irdyOe && !pciOut.irdyN && !trdyN;
         take = (c == 0) || (pciOut.frameOe && !pciOut.frameN &&
            (pciOut.irdyN || comp) && !prevRdy);
         if (comp) begin
            check(pciOut.ad, patWord(got));
            check(64'(pciOut.cbe), 64'(patEnable(got)));
            check(64'(burstWordsRemaining), 64'(len - got));
            got++;
         end
         // Strobes pulse only in the cycle after a pair is taken; status shows data.
         if (c > 0) begin
            check(64'({lowN, highN, masterStateCode}),
               64'({!lastTake, !lastTake, pmbf_pkg::CODE_DATA}));
         end
         lastTake = take;
         prevRdy = localIn.readyN;
         if (take) k++;
         if (take && k == pauseAt) pause = 3;
         // Ready stays on, except during a pause, until the final pair is taken, so a stalled target cannot strand it.
         localIn <= '{patWord(k), patEnable(k), (k >= len) || (pause > 0)};
         if (pause > 0) pause--;
         start <= 1'b0;
         stall <= (c >= stallAt) && (c < stallAt + 2);
      end
      check(64'(got), 64'(len));
      @(posedge clk);
      stall <= 1'b0;
      check(64'({pciOut.adOe, pciOut.cbeOe, pciOut.frameOe, pciOut.req64Oe}), 64'h0);
      check(64'({pciOut.irdyN, burstDone, burstWordsRemaining}), 64'h300);
      check(64'({masterStateCode, terminationKind}),
         64'({pmbf_pkg::CODE_BUS_TERM, pmbf_pkg::TERM_NORMAL}));
      @(posedge clk);
      check(64'({pciOut.irdyOe, lowN, highN}), 64'h3);
   endtask

   // Three phases with a prompt target.
   task automatic testBasic();
      runBurst(3, 99, 99);
      $display("test basic done");
   endtask

   // A single phase drops frame in its first cycle.
   task automatic testSingle();
      runBurst(1, 99, 99);
      $display("test single done");
   endtask

   // Target wait states in mid-burst must hold counter and data.
   task automatic testTargetWait();
      runBurst(5, 3, 99);
      $display("test target wait done");
   endtask

   // Local master drops ready in mid-burst, so initiator ready must wait.
   task automatic testLocalPause();
      runBurst(6, 99, 2);
      $display("test local pause done");
   endtask

   // Refused starts, then a burst whose first phase meets a stalled target.
   task automatic testRefused();
      start <= 1'b1;
      burstLength <= 8'h02;
      @(posedge clk);
      burstLength <= 8'h00;
      localIn.readyN <= 1'b0;
      @(posedge clk);
      start <= 1'b0;
      repeat (2) @(posedge clk);
      check(64'({pciOut.irdyOe, masterStateCode}), 64'h0);
      runBurst(2, 0, 99);
      $display("test refused done");
   endtask

   // Reset, then every scenario in turn.
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      check(64'({pciOut.adOe, pciOut.irdyOe, pciOut.irdyN, lowN}), 64'h3);
      testBasic();
      testSingle();
      testTargetWait();
      testLocalPause();
      testRefused();
      testDone();
   end
endmodule
